// File: inc/cds_params.svh
/*
  Constants for the configuration-defaults and status-word block: link framing,
  register addresses, unlock key, status codes, factory values and timing.
  Assumes a single 25 MHz clock on both ends of the serial link.
*/
`ifndef CDS_PARAMS_SVH
`define CDS_PARAMS_SVH

`define CDS_W            16
`define CDS_FRAME_BITS   6'h20
`define CDS_LAST_BIT     6'h1F
`define CDS_CMD_BITS     6'h10
`define CDS_CMD_LAST     6'h0F
`define CDS_WR_BIT       15
`define CDS_ADDR_HI      14
`define CDS_ADDR_LO      8

`define CDS_NREG         3
`define CDS_ADDR_IDENT   7'h01
`define CDS_ADDR_CFG0    7'h02
`define CDS_ADDR_CFG1    7'h03
`define CDS_ADDR_KEY     7'h04
`define CDS_ADDR_CTRL    7'h05
`define CDS_ADDR_NVCNT   7'h06

`define CDS_UNLOCK_KEY   16'h0C1C
`define CDS_CTRL_SAVE    0
`define CDS_CTRL_FACT    1

`define CDS_CODE_BOOT    16'h10AD
`define CDS_CODE_BAD     16'h0BAD
`define CDS_CODE_GOOD    16'h600D
`define CDS_RESV_NIB     4'hE

// Factory identifier value is arbitrary
`define CDS_FACT_IDENT   16'h5A31
`define CDS_FACT_CFG     16'h0000

`define CDS_CLK_NS       40
`define CDS_SCLK_NS      320
`define CDS_HALF_CYC     (`CDS_SCLK_NS / (2 * `CDS_CLK_NS))
`define CDS_DEV_START_US 50
`define CDS_DEV_START_CYC ((`CDS_DEV_START_US * 1000 + `CDS_CLK_NS - 1) / `CDS_CLK_NS)
`define CDS_HOST_WAIT_US 60
`define CDS_HOST_WAIT_CYC ((`CDS_HOST_WAIT_US * 1000 + `CDS_CLK_NS - 1) / `CDS_CLK_NS)

`endif

// File: inc/cds_pkg.sv
/*
  Types for the configuration-defaults link: boot status for the device, operations and states for the host.
  Assumes cds_params.svh supplies all numeric constants.
*/
package cds_pkg;

  typedef enum logic [1:0] {
    CDS_ST_NORM = 2'b00,
    CDS_ST_WAIT = 2'b01,
    CDS_ST_BAD  = 2'b10,
    CDS_ST_GOOD = 2'b11
  } cds_status_t;

  typedef enum logic [1:0] {
    CDS_OP_RW      = 2'b00,
    CDS_OP_STORE   = 2'b01,
    CDS_OP_RESTORE = 2'b10
  } cds_op_t;

  typedef enum logic [2:0] {
    CDS_H_WAIT = 3'b000,
    CDS_H_IDLE = 3'b001,
    CDS_H_LEAD = 3'b010,
    CDS_H_BITS = 3'b011,
    CDS_H_TAIL = 3'b100,
    CDS_H_GAP  = 3'b101
  } cds_hstate_t;

endpackage

// File: inc/cds_spi_if.sv
/*
  Four-wire serial link between the host (master) and the device.
  Assumes each end samples the pins it receives through its own synchroniser.
*/
`timescale 1ns/1ns
interface cds_spi_if;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso;

  modport dev  (input sclk, input ss_n, input mosi, output miso);
  modport host (output sclk, output ss_n, output mosi, input miso);
endinterface

// File: src/cds_device.sv
/*
  Device end: live registers, key-guarded store/restore of power-up defaults in
  non-volatile storage, self-reset with reload, and the first-word status code.
  Assumes a host that frames 32-bit transfers (command word then data word,
  mode 0, MSB first) and a power-on reset por_n separate from the pin reset.
*/
`timescale 1ns/1ns
`include "cds_params.svh"
module cds_device (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         por_n,
  input  wire logic         boot_mode,
  input  wire logic         boot_frame_ok,
  input  wire logic         app_update,
  cds_spi_if.dev            spi,
  output logic [15:0]       system_identifier,
  output logic [15:0]       cfg0,
  output logic [15:0]       cfg1,
  output logic [15:0]       nv_writes,
  output logic              nv_custom,
  output logic              self_reset
);

  logic [1:0]               sclk_s_q;
  logic [1:0]               ss_s_q;
  logic [1:0]               mosi_s_q;
  logic                     sclk_p_q;
  logic                     ss_p_q;
  logic                     ss_act;
  logic                     ss_fall;
  logic                     ss_rise;
  logic                     rise;
  logic                     fall;
  logic [11:0]              start_q;
  logic                     starting;
  logic                     load_q;
  logic                     soft_rst_q;
  logic                     ign_q;
  logic [5:0]               bit_q;
  logic [15:0]              rx_q;
  logic [15:0]              cmd_q;
  logic [15:0]              tx_q;
  logic [15:0]              wr_data;
  logic [6:0]               wr_addr;
  logic                     wr_stb;
  logic                     arm_q;
  logic                     op_save;
  logic                     op_fact;
  logic [15:0]              regs_q [0:`CDS_NREG-1];
  logic [15:0]              nv_q   [0:`CDS_NREG-1];
  logic [15:0]              nv_cnt_q;
  logic                     nv_custom_q;
  logic [15:0]              first_word;
  logic [15:0]              rd_word;
  cds_pkg::cds_status_t     stat_q;

  // Pins from the host pass two flops before anything reads them
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_s_q <= 2'h0;
      ss_s_q   <= 2'h3;
      mosi_s_q <= 2'h0;
      sclk_p_q <= 1'b0;
      ss_p_q   <= 1'b1;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[0], spi.sclk};
      ss_s_q   <= {ss_s_q[0], spi.ss_n};
      mosi_s_q <= {mosi_s_q[0], spi.mosi};
      sclk_p_q <= sclk_s_q[1];
      ss_p_q   <= ss_s_q[1];
    end
  end

  assign ss_act  = ~ss_s_q[1];
  assign ss_fall = ss_act & ss_p_q;
  assign ss_rise = ~ss_act & ~ss_p_q;
  assign rise    = ss_act & sclk_s_q[1] & ~sclk_p_q;
  assign fall    = ss_act & ~sclk_s_q[1] & sclk_p_q;

  // Startup window after pin or self reset; frames begun in it write nothing and open with the bootloader code
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      start_q <= 12'(`CDS_DEV_START_CYC);
    else if (soft_rst_q)
      start_q <= 12'(`CDS_DEV_START_CYC);
    else if (start_q != 12'h000)
      start_q <= start_q - 12'h001;
  end
  assign starting = (start_q != 12'h000);
  // Frame receive: command word in the first half, data word in the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_q <= 6'h00;
      rx_q  <= 16'h0000;
      cmd_q <= 16'h0000;
      ign_q <= 1'b0;
    end
    else if (ss_fall)
    begin
      bit_q <= 6'h00;
      ign_q <= starting;
    end
    else if (rise && bit_q != `CDS_FRAME_BITS)
    begin
      bit_q <= bit_q + 6'h01;
      rx_q  <= {rx_q[14:0], mosi_s_q[1]};
      if (bit_q == `CDS_CMD_LAST)
        cmd_q <= {rx_q[14:0], mosi_s_q[1]};
    end
  end
  assign wr_data = {rx_q[14:0], mosi_s_q[1]};
  assign wr_addr = cmd_q[`CDS_ADDR_HI:`CDS_ADDR_LO];
  // A short frame never reaches the last bit, so it writes nothing
  assign wr_stb  = rise & ~ign_q & (bit_q == `CDS_LAST_BIT) & cmd_q[`CDS_WR_BIT];
  // Key arms only the very next write; any other write disarms it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      arm_q <= 1'b0;
    else if (soft_rst_q)
      arm_q <= 1'b0;
    else if (wr_stb)
      arm_q <= (wr_addr == `CDS_ADDR_KEY) && (wr_data == `CDS_UNLOCK_KEY);
  end
  // Store has priority when both bits are written together
  assign op_save = wr_stb & arm_q & (wr_addr == `CDS_ADDR_CTRL) & wr_data[`CDS_CTRL_SAVE];
  assign op_fact = wr_stb & arm_q & (wr_addr == `CDS_ADDR_CTRL) & ~wr_data[`CDS_CTRL_SAVE]
                   & wr_data[`CDS_CTRL_FACT];
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      soft_rst_q <= 1'b0;
      load_q     <= 1'b1;
    end
    else
    begin
      soft_rst_q <= op_save | op_fact;
      load_q     <= soft_rst_q;
    end
  end
  // Non-volatile side only follows power-on; pin and self resets leave it alone
  always_ff @(posedge mclk or negedge por_n)
  begin
    if (!por_n)
    begin
      nv_custom_q <= 1'b0;
      nv_cnt_q    <= 16'h0000;
    end
    else
    begin
      if (op_save | op_fact)
        nv_cnt_q <= nv_cnt_q + 16'h0001;
      if (app_update)
        nv_custom_q <= 1'b0;
      else if (op_save)
        nv_custom_q <= 1'b1;
      else if (op_fact)
        nv_custom_q <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CDS_NREG; gi++)
    begin : g_reg
      localparam logic [6:0]  ADDR = 7'(`CDS_ADDR_IDENT + gi);
      localparam logic [15:0] FACT = (gi == 0) ? `CDS_FACT_IDENT : `CDS_FACT_CFG;
      // Storage array holds no reset so defaults survive pin resets
      always_ff @(posedge mclk)
      begin
        if (op_save)
          nv_q[gi] <= regs_q[gi];
      end
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          regs_q[gi] <= FACT;
        else if (load_q)
          regs_q[gi] <= nv_custom_q ? nv_q[gi] : FACT;
        else if (wr_stb && wr_addr == ADDR
                 && !(gi == 0 && wr_data[15:12] == `CDS_RESV_NIB))
          regs_q[gi] <= wr_data;
      end
    end
  endgenerate
  // Boot status enters waiting on the next clock, then advances at the close of each frame
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      stat_q <= cds_pkg::CDS_ST_NORM;
    else if (!boot_mode)
      stat_q <= cds_pkg::CDS_ST_NORM;
    else if (stat_q == cds_pkg::CDS_ST_NORM)
      stat_q <= cds_pkg::CDS_ST_WAIT;
    else if (ss_rise)
      stat_q <= boot_frame_ok ? cds_pkg::CDS_ST_GOOD : cds_pkg::CDS_ST_BAD;
  end
  always_comb
  begin
    first_word = regs_q[0];
    if (starting)
      first_word = `CDS_CODE_BOOT;
    else
      case (stat_q)
        cds_pkg::CDS_ST_NORM: first_word = regs_q[0];
        cds_pkg::CDS_ST_WAIT: first_word = `CDS_CODE_BOOT;
        cds_pkg::CDS_ST_BAD:  first_word = `CDS_CODE_BAD;
        cds_pkg::CDS_ST_GOOD: first_word = `CDS_CODE_GOOD;
        default:              first_word = regs_q[0];
      endcase
  end

  always_comb
  begin
    rd_word = 16'h0000;
    case (wr_addr)
      `CDS_ADDR_IDENT: rd_word = regs_q[0];
      `CDS_ADDR_CFG0:  rd_word = regs_q[1];
      `CDS_ADDR_CFG1:  rd_word = regs_q[2];
      `CDS_ADDR_CTRL:  rd_word = {14'h0000, nv_custom_q, arm_q};
      `CDS_ADDR_NVCNT: rd_word = nv_cnt_q;
      default:         rd_word = 16'h0000;
    endcase
  end

  // Output shifts on falling edges; data word loads at the sixteenth fall
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tx_q <= 16'h0000;
    else if (ss_fall)
      tx_q <= first_word;
    else if (fall)
    begin
      if (bit_q == `CDS_CMD_BITS)
        tx_q <= rd_word;
      else
        tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  assign spi.miso   = tx_q[15];
  assign system_identifier = regs_q[0];
  assign cfg0       = regs_q[1];
  assign cfg1       = regs_q[2];
  assign nv_writes  = nv_cnt_q;
  assign nv_custom  = nv_custom_q;
  assign self_reset = soft_rst_q;
endmodule

// File: src/cds_host.sv
/*
  Host end: master of the serial link. Runs single register transfers and the
  two-frame key-guarded store and restore sequences, then waits out the
  device's restart. Assumes a device answering 32-bit mode 0 frames.
*/
`timescale 1ns/1ns
`include "cds_params.svh"
module cds_host (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         op_req,
  input  wire logic [1:0]   op_code,
  input  wire logic         op_wr,
  input  wire logic [6:0]   op_addr,
  input  wire logic [15:0]  op_wdata,
  input  wire logic [15:0]  expect_id,
  cds_spi_if.host           spi,
  output logic              busy,
  output logic              done,
  output logic [15:0]       rdata,
  output logic [15:0]       first_word,
  output logic              id_match
);

  cds_pkg::cds_hstate_t     st_q;
  logic [11:0]              cnt_q;
  logic [5:0]               bit_q;
  logic [31:0]              tx_q;
  logic [31:0]              rx_q;
  logic [31:0]              next_q;
  logic                     two_q;
  logic                     reboot_q;
  logic                     sclk_q;
  logic                     ss_n_q;
  logic                     done_q;
  logic [1:0]               miso_s_q;
  logic [15:0]              ctrl_word;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      miso_s_q <= 2'h0;
    else
      miso_s_q <= {miso_s_q[0], spi.miso};
  end

  assign ctrl_word = (op_code == cds_pkg::CDS_OP_STORE) ? (16'h0001 << `CDS_CTRL_SAVE)
                                                       : (16'h0001 << `CDS_CTRL_FACT);

  // Half periods are counted on mclk; the link clock is a divided copy
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q     <= cds_pkg::CDS_H_WAIT;
      cnt_q    <= 12'(`CDS_HOST_WAIT_CYC);
      bit_q    <= 6'h00;
      tx_q     <= 32'h0000_0000;
      rx_q     <= 32'h0000_0000;
      next_q   <= 32'h0000_0000;
      two_q    <= 1'b0;
      reboot_q <= 1'b0;
      sclk_q   <= 1'b0;
      ss_n_q   <= 1'b1;
      done_q   <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        cds_pkg::CDS_H_WAIT:
        begin
          if (cnt_q == 12'h000)
            st_q <= cds_pkg::CDS_H_IDLE;
          else
            cnt_q <= cnt_q - 12'h001;
        end
        cds_pkg::CDS_H_IDLE:
        begin
          if (op_req)
          begin
            // Key frame first, then the control bit frame
            if (op_code == cds_pkg::CDS_OP_STORE || op_code == cds_pkg::CDS_OP_RESTORE)
            begin
              tx_q   <= {1'b1, `CDS_ADDR_KEY, 8'h00, `CDS_UNLOCK_KEY};
              next_q <= {1'b1, `CDS_ADDR_CTRL, 8'h00, ctrl_word};
              two_q    <= 1'b1;
              reboot_q <= 1'b1;
            end
            else
            begin
              tx_q     <= {op_wr, op_addr, 8'h00, op_wdata};
              two_q    <= 1'b0;
              reboot_q <= 1'b0;
            end
            ss_n_q <= 1'b0;
            cnt_q  <= 12'h000;
            bit_q  <= 6'h00;
            st_q   <= cds_pkg::CDS_H_LEAD;
          end
        end
        cds_pkg::CDS_H_LEAD:
        begin
          if (cnt_q == 12'(2 * `CDS_HALF_CYC - 1))
          begin
            cnt_q <= 12'h000;
            st_q  <= cds_pkg::CDS_H_BITS;
          end
          else
            cnt_q <= cnt_q + 12'h001;
        end
        cds_pkg::CDS_H_BITS:
        begin
          if (cnt_q == 12'(`CDS_HALF_CYC - 1))
          begin
            cnt_q  <= 12'h000;
            sclk_q <= ~sclk_q;
            // Sampling on the fall leaves room for both synchronisers
            if (sclk_q)
            begin
              rx_q  <= {rx_q[30:0], miso_s_q[1]};
              tx_q  <= {tx_q[30:0], 1'b0};
              bit_q <= bit_q + 6'h01;
              if (bit_q == `CDS_LAST_BIT)
                st_q <= cds_pkg::CDS_H_TAIL;
            end
          end
          else
            cnt_q <= cnt_q + 12'h001;
        end
        cds_pkg::CDS_H_TAIL:
        begin
          if (cnt_q == 12'(`CDS_HALF_CYC - 1))
          begin
            cnt_q  <= 12'h000;
            ss_n_q <= 1'b1;
            st_q   <= cds_pkg::CDS_H_GAP;
          end
          else
            cnt_q <= cnt_q + 12'h001;
        end
        cds_pkg::CDS_H_GAP:
        begin
          if (cnt_q == 12'(2 * `CDS_HALF_CYC - 1))
          begin
            cnt_q <= 12'h000;
            bit_q <= 6'h00;
            if (two_q)
            begin
              two_q  <= 1'b0;
              tx_q   <= next_q;
              ss_n_q <= 1'b0;
              st_q   <= cds_pkg::CDS_H_LEAD;
            end
            else
            begin
              done_q <= 1'b1;
              if (reboot_q)
              begin
                cnt_q <= 12'(`CDS_HOST_WAIT_CYC);
                st_q  <= cds_pkg::CDS_H_WAIT;
              end
              else
                st_q <= cds_pkg::CDS_H_IDLE;
            end
          end
          else
            cnt_q <= cnt_q + 12'h001;
        end
        default:
          st_q <= cds_pkg::CDS_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata      <= 16'h0000;
      first_word <= 16'h0000;
      id_match   <= 1'b0;
    end
    else if (st_q == cds_pkg::CDS_H_TAIL && cnt_q == 12'h000)
    begin
      rdata      <= rx_q[15:0];
      first_word <= rx_q[31:16];
      id_match   <= (rx_q[31:16] == expect_id);
    end
  end

  assign spi.sclk = sclk_q;
  assign spi.ss_n = ss_n_q;
  assign spi.mosi = tx_q[31];
  assign busy     = (st_q != cds_pkg::CDS_H_IDLE);
  assign done     = done_q;

endmodule

// File: tb/cds_link_monitor.sv
/*
  Checker for the serial link between host and device: framing, clock widths,
  data stability and bit count per frame.
  Assumes it is instantiated beside the link interface, fed by plain signals.
*/
`timescale 1ns/1ns
module cds_link_monitor (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic sclk,
  input  wire logic ss_n,
  input  wire logic mosi,
  input  wire logic miso
);
  logic [5:0] rises_q;

  default clocking mon_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Counts link clock rises inside a frame, cleared between frames
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rises_q <= 6'h00;
    else if (ss_n)
      rises_q <= 6'h00;
    else if ($rose(sclk))
      rises_q <= rises_q + 6'h01;
  end

  a_idle_sclk_low: assert property (ss_n |-> !sclk)
    else $error("link clock active outside a frame");
  a_lead_before_bits: assert property ($fell(ss_n) |-> !sclk [*7])
    else $error("link clock started too soon after select");
  a_clock_high_width: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase not four cycles");
  a_clock_low_width: assert property ($fell(sclk) && !ss_n |-> !sclk [*4])
    else $error("link clock low phase shorter than four cycles");
  a_mosi_held_high: assert property (sclk |-> $stable(mosi))
    else $error("host data moved while link clock high");
  a_miso_held_high: assert property (sclk && !ss_n |-> $stable(miso))
    else $error("device data moved while link clock high");
  a_frame_bit_count: assert property ($rose(ss_n) |-> rises_q == 6'h20)
    else $error("frame did not carry two full words");
  a_frame_duration: assert property ($fell(ss_n) |-> ##[264:272] $rose(ss_n))
    else $error("frame length out of range");
  a_gap_after_frame: assert property ($rose(ss_n) |-> ss_n [*8])
    else $error("gap between frames too short");
endmodule

// File: tb/config_defaults_and_status_word_test.sv
/*
  Self-checking bench: host and device joined by the link, user sides driven.
  Assumes the constants of cds_params.svh and the types of cds_pkg.
*/
`timescale 1ns/1ns
`include "cds_params.svh"
module config_defaults_and_status_word_test;
  typedef struct {
    logic [15:0] fw;
    logic [15:0] rd;
    logic        chk;
    logic        idm;
  } cds_note_t;

  logic        mclk;
  logic        rst_n;
  logic        por_n;
  logic        boot_mode;
  logic        boot_frame_ok;
  logic        app_update;
  logic        op_req;
  logic [1:0]  op_code;
  logic        op_wr;
  logic [6:0]  op_addr;
  logic [15:0] op_wdata;
  logic [15:0] expect_id;
  logic        busy;
  logic        done;
  logic [15:0] rdata;
  logic [15:0] first_word;
  logic        id_match;
  logic [15:0] system_identifier;
  logic [15:0] cfg0;
  logic [15:0] cfg1;
  logic [15:0] nv_writes;
  logic        nv_custom;
  logic        self_reset;
  int          failures;
  int          checked;
  int          resets_seen;
  cds_note_t   notes[$];
  cds_note_t   note;
  logic [15:0] val_s;
  logic [15:0] val_c;
  logic [15:0] val_d;
  logic [15:0] codes [3];

  cds_spi_if link ();
  cds_device cds_device_i (.mclk(mclk), .rst_n(rst_n), .por_n(por_n), .boot_mode(boot_mode),
    .boot_frame_ok(boot_frame_ok), .app_update(app_update), .spi(link.dev),
    .system_identifier(system_identifier), .cfg0(cfg0), .cfg1(cfg1), .nv_writes(nv_writes),
    .nv_custom(nv_custom), .self_reset(self_reset));
  cds_host cds_host_i (.mclk(mclk), .rst_n(rst_n), .op_req(op_req), .op_code(op_code), .op_wr(op_wr),
    .op_addr(op_addr), .op_wdata(op_wdata), .expect_id(expect_id), .spi(link.host), .busy(busy),
    .done(done), .rdata(rdata), .first_word(first_word), .id_match(id_match));
  cds_link_monitor cds_link_monitor_i (.mclk(mclk), .rst_n(rst_n), .sclk(link.sclk), .ss_n(link.ss_n),
    .mosi(link.mosi), .miso(link.miso));

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  task automatic print_verdict();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One host operation; the expected answer is queued before the request goes out
  task automatic run_op(input logic [1:0] code, input logic wr, input logic [6:0] addr, input logic [15:0] wd,
                        input logic [15:0] eid, input logic [15:0] fw, input logic [15:0] rd, input logic chk);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge mclk);
      n++;
    end
    notes.push_back('{fw, rd, chk, fw == eid});
    op_code   <= code;
    op_wr     <= wr;
    op_addr   <= addr;
    op_wdata  <= wd;
    expect_id <= eid;
    op_req    <= 1'b1;
    @(posedge mclk);
    op_req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (done !== 1'b1 && n < 4000);
    if (n >= 4000)
      failures++;
  endtask

  task automatic read_reg(input logic [6:0] a, input logic [15:0] fw, input logic [15:0] exp);
    run_op(cds_pkg::CDS_OP_RW, 1'b0, a, 16'h0000, fw, fw, exp, 1'b1);
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [15:0] d, input logic [15:0] fw);
    run_op(cds_pkg::CDS_OP_RW, 1'b1, a, d, fw, fw, 16'h0000, 1'b0);
  endtask

  // Pin reset only: non-volatile side keeps its contents
  task automatic pin_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
  endtask

  always @(posedge mclk)
  begin
    if (self_reset === 1'b1)
      resets_seen++;
  end

  // Result watcher: oldest queued note against each finished operation
  always @(posedge mclk)
  begin
    if (done === 1'b1)
    begin
      if (notes.size() == 0)
      begin
        failures++;
        $display("BAD note queue expected entry seen none");
      end
      else
      begin
        note = notes.pop_front();
        check16("first_word", note.fw, first_word);
        check1("id_match", note.idm, id_match);
        if (note.chk)
          check16("rdata", note.rd, rdata);
      end
    end
  end

  initial
  begin
    repeat (40000) @(posedge mclk);
    failures++;
    print_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    por_n = 1'b0;
    boot_mode = 1'b0;
    boot_frame_ok = 1'b0;
    app_update = 1'b0;
    op_req = 1'b0;
    op_code = 2'b00;
    op_wr = 1'b0;
    op_addr = 7'h00;
    op_wdata = 16'h0000;
    expect_id = 16'h0000;
    failures = 0;
    checked = 0;
    resets_seen = 0;
    val_c = 16'($urandom(39043));
    val_c = 16'($urandom);
    val_d = 16'($urandom);
    val_s = {4'h3, val_d[11:0]};
    codes = '{`CDS_CODE_BOOT, `CDS_CODE_BAD, `CDS_CODE_GOOD};
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    read_reg(`CDS_ADDR_IDENT, `CDS_FACT_IDENT, `CDS_FACT_IDENT);
    write_reg(`CDS_ADDR_IDENT, {4'hE, val_c[11:0]}, `CDS_FACT_IDENT);
    read_reg(`CDS_ADDR_IDENT, `CDS_FACT_IDENT, `CDS_FACT_IDENT);
    check16("system_identifier", `CDS_FACT_IDENT, system_identifier);
    write_reg(`CDS_ADDR_IDENT, val_s, `CDS_FACT_IDENT);
    write_reg(7'h02, val_c, val_s);
    run_op(cds_pkg::CDS_OP_RW, 1'b0, 7'h02, 16'h0000, `CDS_FACT_IDENT, val_s, val_c, 1'b1);
    // Control write without key, then key disarmed by another write
    write_reg(`CDS_ADDR_CTRL, 16'h0001, val_s);
    write_reg(`CDS_ADDR_KEY, `CDS_UNLOCK_KEY, val_s);
    write_reg(7'h03, val_d, val_s);
    write_reg(`CDS_ADDR_CTRL, 16'h0001, val_s);
    read_reg(`CDS_ADDR_NVCNT, val_s, 16'h0000);
    check16("self_resets", 16'h0000, 16'(resets_seen));
    run_op(cds_pkg::CDS_OP_STORE, 1'b0, 7'h00, 16'h0000, val_s, val_s, 16'h0000, 1'b0);
    read_reg(`CDS_ADDR_NVCNT, val_s, 16'h0001);
    check16("nv_writes", 16'h0001, nv_writes);
    check16("system_identifier", val_s, system_identifier);
    check16("cfg0", val_c, cfg0);
    check16("cfg1", val_d, cfg1);
    check1("nv_custom", 1'b1, nv_custom);
    check16("self_resets", 16'h0001, 16'(resets_seen));
    write_reg(7'h02, val_d, val_s);
    pin_reset();
    read_reg(7'h02, val_s, val_c);
    app_update <= 1'b1;
    @(posedge mclk);
    app_update <= 1'b0;
    pin_reset();
    check1("nv_custom", 1'b0, nv_custom);
    read_reg(7'h02, `CDS_FACT_IDENT, `CDS_FACT_CFG);
    write_reg(7'h02, val_d, `CDS_FACT_IDENT);
    run_op(cds_pkg::CDS_OP_STORE, 1'b0, 7'h00, 16'h0000, 16'h0000, `CDS_FACT_IDENT, 16'h0000, 1'b0);
    read_reg(7'h02, `CDS_FACT_IDENT, val_d);
    run_op(cds_pkg::CDS_OP_RESTORE, 1'b0, 7'h00, 16'h0000, 16'h0000, `CDS_FACT_IDENT, 16'h0000, 1'b0);
    read_reg(7'h02, `CDS_FACT_IDENT, `CDS_FACT_CFG);
    read_reg(`CDS_ADDR_NVCNT, `CDS_FACT_IDENT, 16'h0003);
    check16("nv_writes", 16'h0003, nv_writes);
    check16("cfg0", `CDS_FACT_CFG, cfg0);
    check16("self_resets", 16'h0003, 16'(resets_seen));
    check1("nv_custom", 1'b0, nv_custom);
    // Bootloader status sequence: waiting, failed block, good block
    boot_mode <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      boot_frame_ok <= (i == 1);
      run_op(cds_pkg::CDS_OP_RW, 1'b0, `CDS_ADDR_IDENT, 16'h0000, codes[i], codes[i], 16'h0000, 1'b0);
    end
    boot_mode <= 1'b0;
    repeat (2) @(posedge mclk);
    check16("pending_notes", 16'h0000, 16'(notes.size()));
    print_verdict();
  end
endmodule
